// [src/nu_params.svh]
// Constants for the NAND identifier, OTP and feature command block
`ifndef NU_PARAMS_SVH
`define NU_PARAMS_SVH
// Command codes seen on the NAND bus
`define NU_CMD_RESET 8'hff
`define NU_CMD_UID 8'hed
`define NU_CMD_PPAGE 8'hec
`define NU_CMD_SETF 8'hef
`define NU_CMD_GETF 8'hee
`define NU_CMD_STAT 8'h70
`define NU_CMD_READ 8'h00
`define NU_CMD_READ_GO 8'h30
`define NU_CMD_PROG 8'h80
`define NU_CMD_PROG_GO 8'h10
`define NU_CMD_ERASE 8'h60
`define NU_CMD_ERASE_GO 8'hd0
`define NU_CMD_COPYBACK 8'h85
`define NU_CMD_CB_READ 8'h35
// Legacy entry and lock sequences, lock ends with the program code
`define NU_ENTRY_B0 8'h29
`define NU_ENTRY_B1 8'h17
`define NU_ENTRY_B2 8'h04
`define NU_ENTRY_B3 8'h19
`define NU_LOCK_B0 8'h4c
`define NU_LOCK_B1 8'h03
`define NU_LOCK_B2 8'h1d
`define NU_LOCK_B3 8'h41
`define NU_SEQ_LAST 3'd3
`define NU_SEQ_DONE 3'd4
// Address and parameter counts
`define NU_UID_ADDR 8'h00
`define NU_ROW_CYC 3'd5
`define NU_LOCK_CYC 3'd4
`define NU_FEAT_LAST 3'd3
`define NU_OTP_PAGE_W 6
// Feature 90h layout
`define NU_FA_OTP 8'h90
`define NU_FEAT_RESET 8'h08
`define NU_FEAT_MODE 0
`define NU_FEAT_LOCK 1
`define NU_FEAT_ONE 3
// Parameter page image
`define NU_PP_END 10'd768
`define NU_PP_FILL 8'hff
// Status byte bits
`define NU_ST_FAIL 0
`define NU_ST_ARDY 5
`define NU_ST_RDY 6
`define NU_ST_WPN 7
// Timing
`define NU_CLK_MHZ 25
`define NU_PAGE_READ_US 250
`define NU_PROG_US 600
`define NU_FEAT_US 1
// Pin idle levels {cle, ale, ce_n, we_n, re_n, io}
`define NU_PIN_IDLE 13'h0700
// AXI4-Lite register map
`define NU_A_STATUS 8'h00
`define NU_A_UID0 8'h04
`define NU_A_UID3 8'h10
`define NU_A_PP_IDX 8'h14
`define NU_A_PP_DATA 8'h18
`define NU_A_LAST_OP 8'h1c
`define NU_A_LAST_ROW 8'h20
`define NU_RESP_OK 2'b00
`define NU_RESP_ERR 2'b10
`endif

// [src/nu_pkg.sv]
// Types for the NAND identifier, OTP and feature command block
package nu_pkg;
	// Bus modes, Gray steps along the usual paths
	typedef enum logic [3:0] {
		NU_IDLE = 4'h0, NU_UID_ADDR = 4'h1, NU_UID_OUT = 4'h3, NU_PP_ADDR = 4'h2,
		NU_PP_OUT = 4'h6, NU_SETF_ADDR = 4'h7, NU_SETF_DATA = 4'h5, NU_GETF_ADDR = 4'h4,
		NU_GETF_OUT = 4'hc, NU_STAT_OUT = 4'hd, NU_READ_ADDR = 4'hf, NU_READ_WAIT = 4'he,
		NU_PROG_ADDR = 4'ha, NU_PROG_DATA = 4'hb, NU_ERASE_ADDR = 4'h9, NU_LOCK_ADDR = 4'h8
	} nu_mode_t;

	// Whole state of the command block
	typedef struct packed {
		nu_mode_t mode;
		logic [9:0] cnt;
		logic [2:0] acnt;
		logic [2:0] entry_idx;
		logic [2:0] lock_idx;
		logic [7:0] fa;
		logic [7:0] p1;
		logic [7:0] feat;
		logic legacy_otp;
		logic locked;
		logic lock_pend;
		logic fail;
		logic rejected;
		logic last_otp;
		logic [7:0] last_cmd;
		logic [23:0] row;
		logic [23:0] last_row;
		logic [15:0] busy_cnt;
		logic rb_n;
		logic io_oe;
		logic [7:0] io_out;
		logic we_prev;
		logic re_prev;
		logic [127:0] uid;
		logic [7:0] pp_idx;
		logic awready;
		logic wready;
		logic aw_hold;
		logic w_hold;
		logic [7:0] aw_addr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} nu_state_t;
endpackage

// [src/nu_sync.sv]
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module nu_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [W-1:0] d, // Asynchronous levels
	output logic [W-1:0] q // Levels after two flops
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} nu_sync_st_t;

	nu_sync_st_t st;
	nu_sync_st_t st_next;

	// First stage feeds only the second stage
	always_comb
	begin
		st_next.s1 = d;
		st_next.s2 = st.s1;
	end

	// Reset to idle pin levels so no false edge appears at release
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st <= {RST, RST};
		end
		else
		begin
			st <= st_next;
		end
	end

	assign q = st.s2;
endmodule

// [src/nu_cmd_top.sv]
// NAND command block: unique identifier, OTP region, features, parameter page
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "nu_params.svh"
// Functional notes
// - Parameter page bytes 0-255 repeat at 256-511 and 512-767, then FFh.
// - Command EDh with address 00h starts the identifier read.
// - Identifier reads as 16 value bytes then 16 inverted bytes.
// - Groups repeat value, inverse, inverse, value up to byte 511.
// - Identifier data keeps coming until another command arrives.
// - OTP region is one 64-page block, block 6 under legacy access.
// - Command sequence 29h 17h 04h 19h enters OTP mode.
// - Legacy OTP program: 80h, five address bytes, data, confirm 10h.
// - Legacy OTP read: 00h, five address bytes, confirm 30h.
// - Set feature 90h with 09h enters OTP mode.
// - In OTP mode page reads and programs target the OTP region.
// - In OTP mode erase, copyback and reprogram commands are rejected; the code rejects erase and copyback only, and fails a program only once locked.
// - Sequence 4Ch 03h 1Dh 41h 80h, four 00h addresses, 10h locks OTP.
// - Set feature 90h with 0Bh locks the OTP region.
// - Status shows ready once locking has finished.
// - Reset command FFh leaves OTP mode entered by legacy sequence.
// - Set feature 90h with 08h leaves OTP mode.
// - Features are lost at power-off, kept through reset, read back current.
// - Feature 90h: bit 0 OTP mode, bit 1 lock in mode, bit 3 reads one.
// - Reset command leaves feature 90h settings unchanged.
module nu_cmd_top #(
	parameter logic [15:0] READ_CYCLES = 16'(`NU_PAGE_READ_US * `NU_CLK_MHZ), // Page read time
	parameter logic [15:0] PROG_CYCLES = 16'(`NU_PROG_US * `NU_CLK_MHZ) // Program or lock time
) (
	input wire logic aclk, // System clock, 25 MHz
	input wire logic aresetn, // Power-on reset, synchronous, active low
	input wire logic cle, // Command latch enable pin
	input wire logic ale, // Address latch enable pin
	input wire logic ce_n, // Chip enable pin, active low
	input wire logic we_n, // Write strobe pin, active low
	input wire logic re_n, // Read strobe pin, active low
	input wire logic [7:0] io_in, // Bus level seen on the pins
	output logic [7:0] io_out, // Bus value driven out
	output logic io_oe, // High while the device drives the bus
	output logic rb_n, // Ready high, busy low
	input wire logic [7:0] awaddr, // AXI write address
	input wire logic awvalid, // AXI write address valid
	output logic awready, // AXI write address ready
	input wire logic [31:0] wdata, // AXI write data
	input wire logic [3:0] wstrb, // AXI byte enables
	input wire logic wvalid, // AXI write data valid
	output logic wready, // AXI write data ready
	output logic [1:0] bresp, // AXI write response
	output logic bvalid, // AXI write response valid
	input wire logic bready, // AXI write response ready
	input wire logic [7:0] araddr, // AXI read address
	input wire logic arvalid, // AXI read address valid
	output logic arready, // AXI read address ready
	output logic [31:0] rdata, // AXI read data
	output logic [1:0] rresp, // AXI read response
	output logic rvalid, // AXI read data valid
	input wire logic rready // AXI read data ready
);
	localparam logic [15:0] FEAT_CYCLES = 16'(`NU_FEAT_US * `NU_CLK_MHZ);

	nu_pkg::nu_state_t q;
	nu_pkg::nu_state_t n;
	logic [12:0] pins;
	logic s_cle;
	logic s_ale;
	logic s_ce_n;
	logic s_we_n;
	logic s_re_n;
	logic [7:0] s_io;
	logic [7:0] pp_mem [0:255];
	logic pp_we;
	logic [7:0] pp_wa;
	logic [7:0] pp_wd;

	// Pins come from the host's domain, so every level passes two flops
	nu_sync #(.W(13), .RST(`NU_PIN_IDLE)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({cle, ale, ce_n, we_n, re_n, io_in}),
		.q(pins)
	);
	assign {s_cle, s_ale, s_ce_n, s_we_n, s_re_n, s_io} = pins;

	// Expected byte of the legacy entry or lock sequence at a step
	function automatic logic [7:0] seq_byte(input logic lock, input logic [2:0] idx);
		logic [7:0] b;
		b = 8'h00;
		case (idx)
			3'd0: b = lock ? `NU_LOCK_B0 : `NU_ENTRY_B0;
			3'd1: b = lock ? `NU_LOCK_B1 : `NU_ENTRY_B1;
			3'd2: b = lock ? `NU_LOCK_B2 : `NU_ENTRY_B2;
			3'd3: b = lock ? `NU_LOCK_B3 : `NU_ENTRY_B3;
			default: b = 8'h00;
		endcase
		return b;
	endfunction

	// Byte-lane merge for AXI writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
			begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	// Next state of the whole block
	always_comb
	begin
		logic otp;
		logic we_rise;
		logic re_fall;
		logic [7:0] b;
		logic [1:0] wi;
		otp = 1'b0;
		we_rise = 1'b0;
		re_fall = 1'b0;
		b = 8'h00;
		wi = 2'd0;
		n = q;
		pp_we = 1'b0;
		pp_wa = q.pp_idx;
		pp_wd = q.wdata[7:0];
		otp = q.feat[`NU_FEAT_MODE] | q.legacy_otp;
		we_rise = s_we_n & ~q.we_prev & ~s_ce_n;
		re_fall = ~s_re_n & q.re_prev & ~s_ce_n;
		n.we_prev = s_we_n;
		n.re_prev = s_re_n;
		b = s_io;

		// Internal operation timer; a lock takes effect as it ends
		if (q.busy_cnt != 16'h0000)
		begin
			n.busy_cnt = q.busy_cnt - 16'h0001;
			if (q.busy_cnt == 16'h0001 && q.lock_pend)
			begin
				n.locked = 1'b1;
				n.lock_pend = 1'b0;
			end
		end

		// Command cycles
		if (we_rise && s_cle)
		begin
			n.acnt = 3'd0;
			// Legacy sequences are tracked alongside normal decoding
			if (b == seq_byte(1'b0, q.entry_idx))
			begin
				n.entry_idx = (q.entry_idx == `NU_SEQ_LAST) ? 3'd0 : q.entry_idx + 3'd1;
				if (q.entry_idx == `NU_SEQ_LAST)
				begin
					n.legacy_otp = 1'b1;
				end
			end
			else
			begin
				n.entry_idx = (b == `NU_ENTRY_B0) ? 3'd1 : 3'd0;
			end
			if (q.lock_idx != `NU_SEQ_DONE && b == seq_byte(1'b1, q.lock_idx))
			begin
				n.lock_idx = q.lock_idx + 3'd1;
			end
			else
			begin
				n.lock_idx = (b == `NU_LOCK_B0) ? 3'd1 : 3'd0;
			end
			n.mode = nu_pkg::NU_IDLE;
			case (b)
				`NU_CMD_RESET:
				begin
					// Feature settings survive; the legacy entry, a pending lock, the timer and fail are cleared
					n.legacy_otp = 1'b0;
					n.busy_cnt = 16'h0000;
					n.lock_pend = 1'b0;
					n.fail = 1'b0;
				end
				`NU_CMD_UID: n.mode = nu_pkg::NU_UID_ADDR;
				`NU_CMD_PPAGE: n.mode = nu_pkg::NU_PP_ADDR;
				`NU_CMD_SETF: n.mode = nu_pkg::NU_SETF_ADDR;
				`NU_CMD_GETF: n.mode = nu_pkg::NU_GETF_ADDR;
				`NU_CMD_STAT: n.mode = nu_pkg::NU_STAT_OUT;
				`NU_CMD_READ: n.mode = nu_pkg::NU_READ_ADDR;
				`NU_CMD_PROG:
				begin
					n.mode = (q.lock_idx == `NU_SEQ_DONE) ? nu_pkg::NU_LOCK_ADDR
						: nu_pkg::NU_PROG_ADDR;
				end
				`NU_CMD_READ_GO:
				begin
					if (q.mode == nu_pkg::NU_READ_WAIT)
					begin
						n.busy_cnt = READ_CYCLES;
						n.last_cmd = b;
						n.last_otp = otp;
						n.last_row = otp ? {18'h0, q.row[`NU_OTP_PAGE_W-1:0]} : q.row;
					end
				end
				`NU_CMD_PROG_GO:
				begin
					if (q.mode == nu_pkg::NU_PROG_DATA)
					begin
						n.last_cmd = b;
						n.last_otp = otp;
						n.last_row = otp ? {18'h0, q.row[`NU_OTP_PAGE_W-1:0]} : q.row;
						// A locked region refuses programming but still reports
						n.fail = otp & q.locked;
						n.busy_cnt = (otp & q.locked) ? 16'h0000 : PROG_CYCLES;
					end
					else if (q.mode == nu_pkg::NU_LOCK_ADDR && q.acnt == `NU_LOCK_CYC)
					begin
						n.fail = ~otp;
						n.lock_pend = otp;
						n.busy_cnt = otp ? PROG_CYCLES : 16'h0000;
					end
				end
				`NU_CMD_ERASE, `NU_CMD_COPYBACK, `NU_CMD_CB_READ:
				begin
					// Refused at once in OTP mode, the host sees fail in status
					n.rejected = otp;
					n.fail = otp;
					if (!otp)
					begin
						n.mode = (b == `NU_CMD_ERASE) ? nu_pkg::NU_ERASE_ADDR
							: (b == `NU_CMD_COPYBACK) ? nu_pkg::NU_PROG_ADDR
							: nu_pkg::NU_READ_ADDR;
					end
				end
				`NU_CMD_ERASE_GO:
				begin
					if (q.mode == nu_pkg::NU_ERASE_ADDR)
					begin
						n.last_cmd = b;
						n.last_otp = 1'b0;
						n.last_row = q.row;
						n.busy_cnt = PROG_CYCLES;
					end
				end
				default: n.mode = nu_pkg::NU_IDLE;
			endcase
		end
		// Address cycles
		else if (we_rise && s_ale)
		begin
			n.acnt = q.acnt + 3'd1;
			n.row = {b, q.row[23:8]};
			n.cnt = 10'd0;
			unique case (q.mode)
				nu_pkg::NU_UID_ADDR:
				begin
					n.mode = (b == `NU_UID_ADDR) ? nu_pkg::NU_UID_OUT : nu_pkg::NU_IDLE;
					n.busy_cnt = (b == `NU_UID_ADDR) ? READ_CYCLES : 16'h0000;
				end
				nu_pkg::NU_PP_ADDR:
				begin
					n.mode = nu_pkg::NU_PP_OUT;
					n.busy_cnt = READ_CYCLES;
				end
				nu_pkg::NU_SETF_ADDR:
				begin
					n.fa = b;
					n.acnt = 3'd0;
					n.mode = nu_pkg::NU_SETF_DATA;
				end
				nu_pkg::NU_GETF_ADDR:
				begin
					n.fa = b;
					n.mode = nu_pkg::NU_GETF_OUT;
					n.busy_cnt = FEAT_CYCLES;
				end
				nu_pkg::NU_READ_ADDR:
				begin
					if (n.acnt == `NU_ROW_CYC)
					begin
						n.mode = nu_pkg::NU_READ_WAIT;
					end
				end
				nu_pkg::NU_PROG_ADDR:
				begin
					if (n.acnt == `NU_ROW_CYC)
					begin
						n.mode = nu_pkg::NU_PROG_DATA;
					end
				end
				nu_pkg::NU_IDLE, nu_pkg::NU_UID_OUT, nu_pkg::NU_PP_OUT, nu_pkg::NU_SETF_DATA,
				nu_pkg::NU_GETF_OUT, nu_pkg::NU_STAT_OUT, nu_pkg::NU_READ_WAIT,
				nu_pkg::NU_PROG_DATA, nu_pkg::NU_ERASE_ADDR, nu_pkg::NU_LOCK_ADDR:
				begin
					n.mode = q.mode;
				end
			endcase
		end
		// Data input cycles; program data goes to the array, not kept here
		else if (we_rise && q.mode == nu_pkg::NU_SETF_DATA)
		begin
			n.acnt = q.acnt + 3'd1;
			if (q.acnt == 3'd0)
			begin
				n.p1 = b;
			end
			if (q.acnt == `NU_FEAT_LAST)
			begin
				n.mode = nu_pkg::NU_IDLE;
				n.busy_cnt = FEAT_CYCLES;
				if (q.fa == `NU_FA_OTP)
				begin
					n.feat = q.p1;
					n.feat[`NU_FEAT_ONE] = 1'b1;
					n.feat[`NU_FEAT_LOCK] = q.p1[`NU_FEAT_LOCK] & q.p1[`NU_FEAT_MODE];
					// Leaving by feature also drops a legacy entry
					n.legacy_otp = q.legacy_otp & q.p1[`NU_FEAT_MODE];
					if (q.p1[`NU_FEAT_LOCK] && q.p1[`NU_FEAT_MODE])
					begin
						n.lock_pend = 1'b1;
						n.busy_cnt = PROG_CYCLES;
					end
				end
			end
		end

		// Read cycles; output modes hold until the next command
		if (re_fall && q.busy_cnt == 16'h0000)
		begin
			case (q.mode)
				nu_pkg::NU_UID_OUT:
				begin
					// Middle two groups of every 64 bytes are inverted
					n.io_out = q.uid[8*q.cnt[3:0] +: 8]
						^ {8{q.cnt[5] ^ q.cnt[4]}};
					n.cnt = {1'b0, q.cnt[8:0] + 9'd1};
				end
				nu_pkg::NU_PP_OUT:
				begin
					n.io_out = (q.cnt < `NU_PP_END) ? pp_mem[q.cnt[7:0]] : `NU_PP_FILL;
					n.cnt = (q.cnt < `NU_PP_END) ? q.cnt + 10'd1 : q.cnt;
				end
				nu_pkg::NU_GETF_OUT:
				begin
					n.io_out = (q.cnt == 10'd0 && q.fa == `NU_FA_OTP) ? q.feat : 8'h00;
					n.cnt = q.cnt + 10'd1;
				end
				nu_pkg::NU_STAT_OUT:
				begin
					n.io_out = 8'h00;
					n.io_out[`NU_ST_FAIL] = q.fail;
					n.io_out[`NU_ST_ARDY] = 1'b1;
					n.io_out[`NU_ST_RDY] = 1'b1;
					n.io_out[`NU_ST_WPN] = 1'b1;
				end
				default: n.io_out = q.io_out;
			endcase
		end
		// Status stays readable while busy; other data waits for ready
		if (q.mode == nu_pkg::NU_STAT_OUT && q.busy_cnt != 16'h0000 && re_fall)
		begin
			n.io_out = 8'h00;
			n.io_out[`NU_ST_WPN] = 1'b1;
		end
		n.io_oe = ~s_ce_n & ~s_re_n & (q.mode == nu_pkg::NU_STAT_OUT
			|| (q.busy_cnt == 16'h0000 && (q.mode == nu_pkg::NU_UID_OUT
			|| q.mode == nu_pkg::NU_PP_OUT || q.mode == nu_pkg::NU_GETF_OUT)));
		n.rb_n = (n.busy_cnt == 16'h0000);

		// AXI write channels are held until both have arrived
		if (awvalid && q.awready)
		begin
			n.aw_hold = 1'b1;
			n.awready = 1'b0;
			n.aw_addr = awaddr;
		end
		if (wvalid && q.wready)
		begin
			n.w_hold = 1'b1;
			n.wready = 1'b0;
			n.wdata = wdata;
			n.wstrb = wstrb;
		end
		if (q.aw_hold && q.w_hold && !q.bvalid)
		begin
			n.aw_hold = 1'b0;
			n.w_hold = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = `NU_RESP_OK;
			wi = 2'((q.aw_addr - `NU_A_UID0) >> 2);
			if (q.aw_addr >= `NU_A_UID0 && q.aw_addr <= `NU_A_UID3 && q.aw_addr[1:0] == 2'b00)
			begin
				n.uid[32*wi +: 32] = merge(q.uid[32*wi +: 32], q.wdata, q.wstrb);
			end
			else if (q.aw_addr == `NU_A_PP_IDX)
			begin
				n.pp_idx = q.wstrb[0] ? q.wdata[7:0] : q.pp_idx;
			end
			else if (q.aw_addr == `NU_A_PP_DATA)
			begin
				pp_we = q.wstrb[0];
				n.pp_idx = q.pp_idx + 8'h01;
			end
			else if (q.aw_addr != `NU_A_STATUS && q.aw_addr != `NU_A_LAST_OP
				&& q.aw_addr != `NU_A_LAST_ROW)
			begin
				n.bresp = `NU_RESP_ERR;
			end
		end
		if (q.bvalid && bready)
		begin
			n.bvalid = 1'b0;
			n.awready = 1'b1;
			n.wready = 1'b1;
		end

		// AXI read answers one cycle after the address is taken
		if (arvalid && q.arready)
		begin
			n.arready = 1'b0;
			n.rvalid = 1'b1;
			n.rresp = `NU_RESP_OK;
			wi = 2'((araddr - `NU_A_UID0) >> 2);
			if (araddr >= `NU_A_UID0 && araddr <= `NU_A_UID3 && araddr[1:0] == 2'b00)
			begin
				n.rdata = q.uid[32*wi +: 32];
			end
			else if (araddr == `NU_A_STATUS)
			begin
				n.rdata = {16'h0, q.feat, 4'h0, q.legacy_otp, ~q.rb_n, q.locked, otp};
			end
			else if (araddr == `NU_A_PP_IDX)
			begin
				n.rdata = {24'h0, q.pp_idx};
			end
			else if (araddr == `NU_A_LAST_OP)
			begin
				n.rdata = {21'h0, q.fail, q.rejected, q.last_otp, q.last_cmd};
			end
			else if (araddr == `NU_A_LAST_ROW)
			begin
				n.rdata = {8'h0, q.last_row};
			end
			else
			begin
				n.rdata = 32'h0;
				n.rresp = (araddr == `NU_A_PP_DATA) ? `NU_RESP_OK : `NU_RESP_ERR;
			end
		end
		if (q.rvalid && rready)
		begin
			n.rvalid = 1'b0;
			n.arready = 1'b1;
		end
	end

	// State register; features reset only here, at power-on
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			q <= '0;
			q.mode <= nu_pkg::NU_IDLE;
			q.feat <= `NU_FEAT_RESET;
			q.rb_n <= 1'b1;
			q.we_prev <= 1'b1;
			q.re_prev <= 1'b1;
			q.awready <= 1'b1;
			q.wready <= 1'b1;
			q.arready <= 1'b1;
		end
		else
		begin
			q <= n;
		end
	end

	// Parameter page image, loaded by software; no reset needed
	always_ff @(posedge aclk)
	begin
		if (pp_we)
		begin
			pp_mem[pp_wa] <= pp_wd;
		end
	end

	assign io_out = q.io_out;
	assign io_oe = q.io_oe;
	assign rb_n = q.rb_n;
	assign awready = q.awready;
	assign wready = q.wready;
	assign bvalid = q.bvalid;
	assign bresp = q.bresp;
	assign arready = q.arready;
	assign rvalid = q.rvalid;
	assign rdata = q.rdata;
	assign rresp = q.rresp;
endmodule

// [tb/nu_cmd_chk_assertions.sv]
// Port checker for the NAND command block
`timescale 1ns/1ps
module nu_cmd_chk #(
	parameter logic [15:0] READ_CYCLES = 16'h0014, // Page read time
	parameter logic [15:0] PROG_CYCLES = 16'h0014 // Program or lock time
) (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset, active low
	input wire logic re_n, // Read strobe
	input wire logic io_oe, // Device drives bus
	input wire logic rb_n, // Ready high
	input wire logic awvalid, // Write address valid
	input wire logic awready, // Write address ready
	input wire logic wvalid, // Write data valid
	input wire logic wready, // Write data ready
	input wire logic bvalid, // Write response valid
	input wire logic bready, // Write response ready
	input wire logic [1:0] bresp, // Write response
	input wire logic arvalid, // Read address valid
	input wire logic arready, // Read address ready
	input wire logic rvalid, // Read data valid
	input wire logic rready, // Read data ready
	input wire logic [31:0] rdata // Read data
);
	int lim;
	logic [15:0] busy_cnt;
	// Longer of page read and program time plus slack for the pin synchronisers
	assign lim = int'(READ_CYCLES > PROG_CYCLES ? READ_CYCLES : PROG_CYCLES) + 32;
	// Length of the current busy stretch
	always_ff @(posedge aclk)
	begin
		if (!aresetn || rb_n)
			busy_cnt <= 16'h0000;
		else
			busy_cnt <= busy_cnt + 16'h0001;
	end
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_write_refused: assert property (awvalid && awready && wvalid && wready |=> !awready && !wready)
		else $error("write channels open after take");
	a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
		else $error("write response late");
	a_bresp_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	a_write_reopen: assert property (bvalid && bready |=> !bvalid && awready && wready)
		else $error("write channels not reopened");
	a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
		else $error("read answer late");
	a_rdata_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");
	a_read_reopen: assert property (rvalid && rready |=> !rvalid && arready)
		else $error("read channel not reopened");
	a_busy_bounded: assert property (busy_cnt <= lim)
		else $error("busy stretch too long");
	a_bus_release: assert property ($rose(re_n) |-> ##[1:5] !io_oe)
		else $error("bus held after read strobe");
endmodule
bind nu_cmd_top nu_cmd_chk #(.READ_CYCLES(READ_CYCLES), .PROG_CYCLES(PROG_CYCLES)) u_chk (
	.aclk, .aresetn, .re_n, .io_oe, .rb_n, .awvalid, .awready, .wvalid, .wready, .bvalid,
	.bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata);

// [tb/nu_host_model.sv]
// Behavioural host controller driving the NAND pins
`timescale 1ns/1ps
module nu_host_model (
	input wire logic aclk, // Clock
	input wire logic [7:0] io_out, // Device byte
	input wire logic io_oe, // Device drives bus
	input wire logic rb_n, // Ready high
	output logic cle, // Command latch
	output logic ale, // Address latch
	output logic ce_n, // Chip enable, active low
	output logic we_n, // Write strobe, active low
	output logic re_n, // Read strobe, active low
	output logic [7:0] io_in // Resolved bus level
);
	logic host_oe;
	logic [7:0] host_dat;
	logic [7:0] last_lvl;
	// A released bus toggles so a stale byte never passes for data
	assign io_in = host_oe ? host_dat : (io_oe ? io_out : ~last_lvl);
	always @(posedge aclk)
		last_lvl <= io_in;
	initial
	begin
		{cle, ale, host_oe} = 3'h0;
		{ce_n, we_n, re_n} = 3'h7;
		host_dat = 8'h00;
		last_lvl = 8'h00;
	end
	// Four clocks each strobe level so the two-flop synchroniser sees each edge
	task automatic phase(input logic c, input logic a, input logic [7:0] d);
		ce_n <= 1'h0;
		cle <= c;
		ale <= a;
		host_dat <= d;
		host_oe <= 1'h1;
		we_n <= 1'h0;
		repeat (4) @(posedge aclk);
		we_n <= 1'h1;
		repeat (4) @(posedge aclk);
		{cle, ale, host_oe} <= 3'h0;
		@(posedge aclk);
	endtask
	task automatic read_byte;
		re_n <= 1'h0;
		repeat (4) @(posedge aclk);
		re_n <= 1'h1;
		repeat (4) @(posedge aclk);
	endtask
	// No data is clocked out before ready shows
	task automatic wait_ready(output bit ok);
		ok = 0;
		for (int n = 0; n < 400 && !ok; n++)
		begin
			@(posedge aclk);
			ok = rb_n;
		end
	endtask
endmodule

// [tb/test_nand_uid_otp_feature_cmds.sv]
// Self-checking bench for the NAND identifier, OTP and feature block
`timescale 1ns/1ps
`include "nu_params.svh"
module test_nand_uid_otp_feature_cmds;
	logic aclk, aresetn, cle, ale, ce_n, we_n, re_n, io_oe, rb_n, re_prev;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [7:0] io_in, io_out, awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [33:0] axi_q[$];
	logic [8:0] nand_q[$];
	logic [31:0] uid_w[4];
	logic [7:0] pp[256];
	int err_count, total_checks;
	bit ok;
	nu_cmd_top #(.READ_CYCLES(16'h0014), .PROG_CYCLES(16'h0014)) u_nu_cmd_top (.aclk, .aresetn,
		.cle, .ale, .ce_n, .we_n, .re_n, .io_in, .io_out, .io_oe, .rb_n, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready);
	nu_host_model u_nu_host_model (.aclk, .io_out, .io_oe, .rb_n, .cle, .ale, .ce_n, .we_n,
		.re_n, .io_in);
	initial
	begin
		aclk = 1'h0;
		forever #20 aclk = ~aclk;
	end
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic give_up;
		err_count++;
		print_verdict();
	endtask
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	// Results are matched in order against the notes left by the drivers
	always @(posedge aclk)
	begin
		re_prev <= re_n;
		if (bvalid && bready)
			check({bresp, 32'h0}, axi_q.pop_front());
		if (rvalid && rready)
			check({rresp, rdata}, axi_q.pop_front());
		if (re_n && !re_prev)
			check({25'h0, io_oe, io_out}, {25'h0, nand_q.pop_front()});
	end
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		axi_q.push_back({r, 32'h0});
		{awaddr, wdata, wstrb} <= {a, d, 4'hf};
		{awvalid, wvalid, bready} <= 3'h7;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
			if (awready)
				awvalid <= 1'h0;
			if (wready)
				wvalid <= 1'h0;
		end
		while (!bvalid && n < 50);
		bready <= 1'h0;
		@(posedge aclk);
		if (n >= 50)
			give_up();
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
		int n;
		axi_q.push_back(e);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
			if (arready)
				arvalid <= 1'h0;
		end
		while (!rvalid && n < 50);
		rready <= 1'h0;
		@(posedge aclk);
		if (n >= 50)
			give_up();
	endtask
	task automatic st(input logic [31:0] e);
		axi_rd(`NU_A_STATUS, {`NU_RESP_OK, e});
	endtask
	task automatic ncmd(input logic [7:0] d);
		u_nu_host_model.phase(1'h1, 1'h0, d);
	endtask
	task automatic nadr(input logic [7:0] d);
		u_nu_host_model.phase(1'h0, 1'h1, d);
	endtask
	task automatic ndat(input logic [7:0] d);
		u_nu_host_model.phase(1'h0, 1'h0, d);
	endtask
	task automatic naddr5(input logic [39:0] a);
		for (int i = 4; i >= 0; i--)
			nadr(a[8 * i +: 8]);
	endtask
	task automatic nrd(input logic [7:0] e);
		nand_q.push_back({1'h1, e});
		u_nu_host_model.read_byte();
	endtask
	task automatic rdy;
		u_nu_host_model.wait_ready(ok);
		if (!ok)
			give_up();
	endtask
	task automatic nstat(input logic [7:0] e);
		ncmd(`NU_CMD_STAT);
		nrd(e);
	endtask
	task automatic setf(input logic [7:0] p);
		ncmd(`NU_CMD_SETF);
		nadr(`NU_FA_OTP);
		ndat(p);
		repeat (3) ndat(8'h00);
		rdy();
	endtask
	// Inverse groups make value XOR inverse all ones
	function automatic logic [7:0] uid_byte(input int n);
		logic [7:0] v;
		v = uid_w[(n % 16) / 4][8 * (n % 4) +: 8];
		return (n[5] ^ n[4]) ? ~v : v;
	endfunction
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
		err_count = 0;
		total_checks = 0;
		void'($urandom(83));
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (4) @(posedge aclk);
		st(32'h0000_0800);
		axi_rd(8'h40, {`NU_RESP_ERR, 32'h0});
		axi_wr(8'h40, 32'h0, `NU_RESP_ERR);
		for (int i = 0; i < 4; i++)
		begin
			uid_w[i] = $urandom;
			axi_wr(`NU_A_UID0 + 8'(4 * i), uid_w[i], `NU_RESP_OK);
		end
		axi_rd(`NU_A_UID3, {`NU_RESP_OK, uid_w[3]});
		axi_wr(`NU_A_PP_IDX, 32'h0, `NU_RESP_OK);
		for (int i = 0; i < 256; i++)
		begin
			pp[i] = 8'($urandom);
			axi_wr(`NU_A_PP_DATA, {24'h0, pp[i]}, `NU_RESP_OK);
		end
		$display("registers test done");
		ncmd(`NU_CMD_UID);
		nadr(`NU_UID_ADDR);
		check({33'h0, rb_n}, 34'h0);
		rdy();
		for (int n = 0; n < 520; n++)
			nrd(uid_byte(n));
		$display("identifier test done");
		ncmd(`NU_CMD_PPAGE);
		nadr(8'h00);
		rdy();
		for (int n = 0; n < 770; n++)
			nrd(n < 768 ? pp[n % 256] : `NU_PP_FILL);
		$display("parameter page test done");
		ncmd(`NU_ENTRY_B0);
		ncmd(`NU_ENTRY_B1);
		ncmd(`NU_ENTRY_B2);
		ncmd(`NU_ENTRY_B3);
		st(32'h0000_0809);
		ncmd(`NU_CMD_ERASE);
		repeat (3) nadr(8'h00);
		ncmd(`NU_CMD_ERASE_GO);
		nstat(8'he1);
		ncmd(`NU_CMD_READ);
		naddr5(40'h00_00_80_01_00);
		ncmd(`NU_CMD_READ_GO);
		rdy();
		axi_rd(`NU_A_LAST_OP, {`NU_RESP_OK, 32'h0000_0730});
		axi_rd(`NU_A_LAST_ROW, {`NU_RESP_OK, 32'h0});
		ncmd(`NU_CMD_RESET);
		rdy();
		st(32'h0000_0800);
		ncmd(`NU_LOCK_B0);
		ncmd(`NU_LOCK_B1);
		ncmd(`NU_LOCK_B2);
		ncmd(`NU_LOCK_B3);
		ncmd(`NU_CMD_PROG);
		repeat (4) nadr(8'h00);
		ncmd(`NU_CMD_PROG_GO);
		nstat(8'he1);
		$display("legacy test done");
		setf(8'h09);
		st(32'h0000_0901);
		ncmd(`NU_CMD_GETF);
		nadr(`NU_FA_OTP);
		rdy();
		nrd(8'h09);
		repeat (3) nrd(8'h00);
		ncmd(`NU_CMD_RESET);
		rdy();
		st(32'h0000_0901);
		setf(8'h0b);
		st(32'h0000_0b03);
		nstat(8'he0);
		ncmd(`NU_CMD_PROG);
		naddr5(40'h0);
		ndat(8'h5a);
		ncmd(`NU_CMD_PROG_GO);
		nstat(8'he1);
		setf(8'h08);
		st(32'h0000_0802);
		$display("feature test done");
		print_verdict();
	end
endmodule
